// >>> rcg_map.svh
// register map, field positions, reset values and timing counts
`ifndef RCG_MAP_SVH
`define RCG_MAP_SVH

// ==========================================================================
// register offsets (byte addresses)
`define RCG_ADDR_W           4
`define RCG_OFS_CLK_CTRL     4'h0
`define RCG_OFS_STATUS       4'h4

// ==========================================================================
// clock control field positions
`define RCG_F_MULT_LO        0
`define RCG_F_MULT_HI        6
`define RCG_F_POST_LO        8
`define RCG_F_POST_HI        9
`define RCG_F_HALVE          10
`define RCG_F_SDR_LO         11
`define RCG_F_SDR_HI         13

// status field positions
`define RCG_F_ST_CORE_RST    0
`define RCG_F_ST_EXT_RST     1
`define RCG_F_ST_STRAP_LO    2
`define RCG_F_ST_STRAP_HI    3

// ==========================================================================
// reset values
`define RCG_RST_POST         2'h0
`define RCG_RST_HALVE        1'h0
`define RCG_RST_SDR          3'h2

// ==========================================================================
// timing counts
`define RCG_RELEASE_REF_CYCLES 4096
`define RCG_TAIL_CORE_CYCLES   2'h2

`endif

// >>> rcg_pkg.sv
// types shared by the clock and reset-release block
package rcg_pkg;

   // clock control register contents
   typedef struct packed {
      logic [2:0] sdram_clock_ratio;
      logic       input_halving_enable;
      logic [1:0] pll_post_divider;
      logic [6:0] pll_multiplier;
   } rcg_pctl_s;

   // avalon-mm request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } rcg_avm_req_s;

   // core reset release sequence
   typedef enum logic [3:0] {
      ST_HOLD  = 4'b0001,
      ST_COUNT = 4'b0010,
      ST_TAIL  = 4'b0100,
      ST_RUN   = 4'b1000
   } rcg_rel_e;

endpackage

// >>> rcg_clock_reset.sv
// clock-enable generation and core reset release with avalon-mm control
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "rcg_map.svh"

// Functional notes
// - In reset, the multiplier comes from the strap-selected ratio.
// - Ratios are set by straps or by software control register writes.
// - Oscillator rate is twice multiplier times PLL input rate.
// - PLL input is the reference, or half of it with halving on.
// - Core rate is oscillator rate over post-divider 2, 4, 8 or 16.
// - Post-divider is forced to divide by two during reset.
// - Peripheral clock period is exactly twice the core clock period.
// - SDRAM clock period is core period times the SDRAM ratio, ratio zero acting as one.
// - Core reset releases 4096 reference cycles plus two core cycles later.
// - A missed setup may add one reference cycle, 4097 at most.
module rcg_clock_reset
#(
   parameter int         RELEASE_REF_CYCLES = `RCG_RELEASE_REF_CYCLES,
   parameter logic [6:0] STRAP_MULT0        = 7'h10,
   parameter logic [6:0] STRAP_MULT1        = 7'h08,
   parameter logic [6:0] STRAP_MULT2        = 7'h04,
   parameter logic [6:0] STRAP_MULT3        = 7'h10
)
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 reference_clock_in,
   input  wire logic                 ext_reset_n,
   input  wire logic [1:0]           clock_ratio_straps,
   input  wire rcg_pkg::rcg_avm_req_s avm_req,
   output logic [31:0]               avm_readdata,
   output logic                      avm_waitrequest,
   output logic                      osc_tick,
   output logic                      core_clock_tick,
   output logic                      periph_clock_tick,
   output logic                      sdram_clock_tick,
   output logic                      core_reset
);
   import rcg_pkg::*;

   localparam int CNT_W = $clog2(RELEASE_REF_CYCLES + 1);
   // ========================================================================
   // pin synchronisers
   // ========================================================================
   logic [3:0] sync1_q, sync1_d;
   logic [3:0] sync2_q, sync2_d;
   logic       ref_prev_q, ref_prev_d;
   logic       ref_edge;
   logic       ext_rst_act;
   logic [1:0] straps_s;
   logic [6:0] strap_mult;

   // two flops per pin, edge detect reads only the second stage
   always_comb
   begin
      sync1_d    = {clock_ratio_straps, ext_reset_n, reference_clock_in};
      sync2_d    = sync1_q;
      ref_prev_d = sync2_q[0];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_q    <= 4'h2;
         sync2_q    <= 4'h2;
         ref_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q    <= sync1_d;
         sync2_q    <= sync2_d;
         ref_prev_q <= ref_prev_d;
      end
   end

   assign ref_edge    = sync2_q[0] & ~ref_prev_q;
   assign ext_rst_act = ~sync2_q[1];
   assign straps_s    = sync2_q[3:2];

   // strap decode to multiplier
   always_comb
   begin
      case (straps_s)
         2'h0:    strap_mult = STRAP_MULT0;
         2'h1:    strap_mult = STRAP_MULT1;
         2'h2:    strap_mult = STRAP_MULT2;
         default: strap_mult = STRAP_MULT3;
      endcase
   end

   // ========================================================================
   // avalon-mm slave and clock control register
   // ========================================================================
   rcg_pctl_s   pctl_q, pctl_d;
   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic        req;
   logic        wr_take;
   logic        core_rst_q;

   assign req     = avm_req.read | avm_req.write;
   assign wr_take = avm_req.write & ~wait_q;
   // one wait cycle per access; data and write effect on the low cycle
   always_comb
   begin
      wait_d  = ~(req & wait_q);
      rdata_d = rdata_q;
      pctl_d  = pctl_q;
      if (avm_req.read & wait_q)
      begin
         rdata_d = 32'h0;
         case (avm_req.address)
            `RCG_OFS_CLK_CTRL: rdata_d[`RCG_F_SDR_HI:`RCG_F_MULT_LO] =
               {pctl_q.sdram_clock_ratio, pctl_q.input_halving_enable,
                pctl_q.pll_post_divider, 1'b0, pctl_q.pll_multiplier};
            `RCG_OFS_STATUS:
            begin
               rdata_d[`RCG_F_ST_CORE_RST] = core_rst_q;
               rdata_d[`RCG_F_ST_EXT_RST]  = ext_rst_act;
               rdata_d[`RCG_F_ST_STRAP_HI:`RCG_F_ST_STRAP_LO] = straps_s;
            end
            default: rdata_d = 32'h0;
         endcase
      end
      if (wr_take && avm_req.address == `RCG_OFS_CLK_CTRL)
      begin
         // software path for the ratios
         pctl_d.pll_multiplier = avm_req.writedata[`RCG_F_MULT_HI:
                                                   `RCG_F_MULT_LO];
         pctl_d.pll_post_divider = avm_req.writedata[`RCG_F_POST_HI:
                                                     `RCG_F_POST_LO];
         pctl_d.input_halving_enable = avm_req.writedata[`RCG_F_HALVE];
         pctl_d.sdram_clock_ratio = avm_req.writedata[`RCG_F_SDR_HI:
                                                      `RCG_F_SDR_LO];
      end
      // straps own the multiplier while the pin holds reset
      if (ext_rst_act)
         pctl_d.pll_multiplier = strap_mult;
      // divide by two until the core leaves reset
      if (core_rst_q)
         pctl_d.pll_post_divider = `RCG_RST_POST;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
         pctl_q <= '{`RCG_RST_SDR, `RCG_RST_HALVE, `RCG_RST_POST,
                     STRAP_MULT0};
      end
      else
      begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         pctl_q  <= pctl_d;
      end
   end

   // ========================================================================
   // oscillator and derived clock enables
   // ========================================================================
   logic [8:0] osc_cred_q, osc_cred_d;
   logic [8:0] inc;
   logic [4:0] div;
   logic [4:0] core_cnt_q, core_cnt_d;
   logic [2:0] sdr_cnt_q, sdr_cnt_d;
   logic       per_ph_q, per_ph_d;
   logic       osc_q, osc_d;
   logic       core_q, core_d;
   logic       per_q, per_d;
   logic       sdr_q, sdr_d;

   // oscillator edges owed per reference edge; halving halves them
   assign inc = pctl_q.input_halving_enable ?
                {2'h0, pctl_q.pll_multiplier} :
                {1'b0, pctl_q.pll_multiplier, 1'b0};
   assign div = 5'(5'h2 << pctl_q.pll_post_divider);

   // the model needs clk faster than the oscillator rate it stands for
   always_comb
   begin
      osc_cred_d = osc_cred_q;
      osc_d      = 1'b0;
      if (osc_cred_q != 9'h0)
      begin
         osc_cred_d = osc_cred_q - 9'h1;
         osc_d      = 1'b1;
      end
      if (ref_edge)
         osc_cred_d = osc_cred_d + inc;
      core_cnt_d = core_cnt_q;
      core_d     = 1'b0;
      if (osc_d)
      begin
         if (core_cnt_q >= div - 5'h1)
         begin
            core_cnt_d = 5'h0;
            core_d     = 1'b1;
         end
         else
            core_cnt_d = core_cnt_q + 5'h1;
      end
      // peripheral: every second core edge
      per_ph_d = per_ph_q ^ core_q;
      per_d    = core_q & per_ph_q;
      // sdram: every ratio core edges, ratio zero acts as one
      sdr_cnt_d = sdr_cnt_q;
      sdr_d     = 1'b0;
      if (core_q)
      begin
         if (sdr_cnt_q + 3'h1 >= pctl_q.sdram_clock_ratio)
         begin
            sdr_cnt_d = 3'h0;
            sdr_d     = 1'b1;
         end
         else
            sdr_cnt_d = sdr_cnt_q + 3'h1;
      end
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         osc_cred_q <= 9'h0;
         core_cnt_q <= 5'h0;
         sdr_cnt_q  <= 3'h0;
         per_ph_q   <= 1'b0;
         osc_q      <= 1'b0;
         core_q     <= 1'b0;
         per_q      <= 1'b0;
         sdr_q      <= 1'b0;
      end
      else
      begin
         osc_cred_q <= osc_cred_d;
         core_cnt_q <= core_cnt_d;
         sdr_cnt_q  <= sdr_cnt_d;
         per_ph_q   <= per_ph_d;
         osc_q      <= osc_d;
         core_q     <= core_d;
         per_q      <= per_d;
         sdr_q      <= sdr_d;
      end
   end

   // ========================================================================
   // core reset release
   // ========================================================================
   rcg_rel_e   st_q, st_d;
   logic [CNT_W-1:0] rel_cnt_q, rel_cnt_d;
   logic [1:0] tail_q, tail_d;

   // counts synchronised reference edges, then two core edges
   always_comb
   begin
      st_d      = st_q;
      rel_cnt_d = rel_cnt_q;
      tail_d    = tail_q;
      case (st_q)
         ST_HOLD:
         begin
            rel_cnt_d = '0;
            tail_d    = 2'h0;
            st_d      = ST_COUNT;
         end
         ST_COUNT:
            if (ref_edge)
            begin
               rel_cnt_d = rel_cnt_q + 1'b1;
               if (rel_cnt_q == CNT_W'(RELEASE_REF_CYCLES - 1))
                  st_d = ST_TAIL;
            end
         ST_TAIL:
            if (core_q)
            begin
               tail_d = tail_q + 2'h1;
               if (tail_q + 2'h1 == `RCG_TAIL_CORE_CYCLES)
                  st_d = ST_RUN;
            end
         ST_RUN:  st_d = ST_RUN;
         default: st_d = ST_HOLD;
      endcase
      // a fresh reset restarts the whole count
      if (ext_rst_act)
      begin
         st_d      = ST_HOLD;
         rel_cnt_d = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q       <= ST_HOLD;
         rel_cnt_q  <= '0;
         tail_q     <= 2'h0;
         core_rst_q <= 1'b1;
      end
      else
      begin
         st_q       <= st_d;
         rel_cnt_q  <= rel_cnt_d;
         tail_q     <= tail_d;
         core_rst_q <= (st_d != ST_RUN);
      end
   end
   // outputs straight from flops
   assign avm_readdata      = rdata_q;
   assign avm_waitrequest   = wait_q;
   assign osc_tick          = osc_q;
   assign core_clock_tick   = core_q;
   assign periph_clock_tick = per_q;
   assign sdram_clock_tick  = sdr_q;
   assign core_reset        = core_rst_q;

   // ========================================================================
   // assertions
   // ========================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_last_ref;
      st_q == ST_COUNT && ref_edge &&
      rel_cnt_q == CNT_W'(RELEASE_REF_CYCLES - 1) && !ext_rst_act;
   endsequence
   sequence s_two_core;
      st_q == ST_TAIL && core_q && !ext_rst_act &&
      tail_q + 2'h1 == `RCG_TAIL_CORE_CYCLES;
   endsequence
   AST_STRAP_LOAD: assert property (ext_rst_act |=>
      pctl_q.pll_multiplier == $past(strap_mult))
      else $error("multiplier not taken from straps");
   AST_SW_WRITE: assert property (wr_take && !ext_rst_act &&
      avm_req.address == `RCG_OFS_CLK_CTRL |=>
      pctl_q.sdram_clock_ratio ==
      $past(avm_req.writedata[`RCG_F_SDR_HI:`RCG_F_SDR_LO]))
      else $error("control write lost");
   AST_OSC_CREDIT: assert property (ref_edge && osc_cred_q == 9'h0 |=>
      osc_cred_q == $past(inc))
      else $error("oscillator credit wrong");
   AST_HALVE: assert property (ref_edge && osc_cred_q == 9'h0 &&
      pctl_q.input_halving_enable |=>
      osc_cred_q == {2'h0, $past(pctl_q.pll_multiplier)})
      else $error("halving not applied");
   AST_CORE_DIV: assert property (osc_q && core_cnt_q == 5'h0 &&
      !core_rst_q ##1 (!osc_q && $stable(pctl_q))[*1] |->
      !core_q)
      else $error("core edge too early");
   AST_RST_DIV2: assert property (core_rst_q |=>
      pctl_q.pll_post_divider == `RCG_RST_POST)
      else $error("post divider not forced");
   AST_PERIPH: assert property (core_q && per_ph_q |=> per_q)
      else $error("peripheral edge missing");
   AST_SDRAM: assert property (sdr_q |-> $past(core_q))
      else $error("sdram edge without core edge");
   AST_RELEASE: assert property (s_last_ref |=> st_q == ST_TAIL)
      else $error("count end not reached");
   AST_TAIL: assert property (s_two_core |=> !core_rst_q)
      else $error("core reset not released");
   AST_RESTART: assert property (ext_rst_act |=>
      rel_cnt_q == '0 ##1 core_rst_q)
      else $error("release count not restarted");
endmodule

// >>> rcg_board_model.sv
// board oscillator, strap pins and external reset source
`timescale 1ns/1ps
module rcg_board_model
#(
   parameter int REF_HALF = 40,
   parameter int HOLD_REF = 6
)
(
   input  wire logic       clk,
   input  wire logic       rst_req,
   input  wire logic [1:0] strap_sel,
   output logic            reference_clock_in,
   output logic            ext_reset_n,
   output logic [1:0]      clock_ratio_straps
);
   int half_cnt = 0;
   int hold_cnt = 0;

   // ==========================================================================
   // oscillator
   // runs free from time zero, so it is stable long before any release
   initial reference_clock_in = 1'b0;
   always @(posedge clk)
   begin
      if (half_cnt == REF_HALF - 1)
      begin
         half_cnt <= 0;
         reference_clock_in <= ~reference_clock_in;
      end
      else
         half_cnt <= half_cnt + 1;
   end

   // ==========================================================================
   // reset source
   // straps only move inside reset and restart the hold count;
   // release lands mid half-period so no reference edge is ambiguous
   initial ext_reset_n = 1'b0;
   initial clock_ratio_straps = 2'h0;
   always @(posedge clk)
   begin
      if (!ext_reset_n && strap_sel != clock_ratio_straps)
      begin
         clock_ratio_straps <= strap_sel;
         hold_cnt <= 0;
      end
      else if (rst_req && ext_reset_n)
      begin
         ext_reset_n <= 1'b0;
         hold_cnt <= 0;
      end
      else if (!ext_reset_n)
      begin
         if (half_cnt == REF_HALF - 1 && !reference_clock_in)
            hold_cnt <= hold_cnt + 1;
         if (!rst_req && hold_cnt >= HOLD_REF && half_cnt == REF_HALF / 2)
            ext_reset_n <= 1'b1;
      end
   end
endmodule

// >>> testbench.sv
// self-checking bench for the clock and reset-release block
`timescale 1ns/1ps
module testbench;
   import rcg_pkg::*;
   localparam logic [6:0] SM [4] = '{7'h0c, 7'h06, 7'h03, 7'h09};
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic          rst_req = 1'b1;
   logic [1:0]    strap_sel = 2'h0;
   logic          reference_clock_in;
   logic          ext_reset_n;
   logic [1:0]    clock_ratio_straps;
   rcg_avm_req_s  avm_req = '0;
   logic [31:0]   avm_readdata;
   logic          avm_waitrequest;
   logic          osc_tick;
   logic          core_clock_tick;
   logic          periph_clock_tick;
   logic          sdram_clock_tick;
   logic          core_reset;
   logic [31:0]   d;
   logic [31:0]   wd;
   logic          ref_q = 1'b0;
   bit            mon_on = 1'b0;
   int            mismatches = 0;
   int            comparisons = 0;
   int            exp_inc, exp_div, exp_sd, m, r, n, ref_cnt = 0;
   int            cnt [4];
   int            sn [4];

   always #4 clk = ~clk;

   rcg_clock_reset #(.RELEASE_REF_CYCLES(8), .STRAP_MULT0(SM[0]),
      .STRAP_MULT1(SM[1]), .STRAP_MULT2(SM[2]), .STRAP_MULT3(SM[3]))
   u_rcg_clock_reset (.clk(clk), .rst(rst),
      .reference_clock_in(reference_clock_in), .ext_reset_n(ext_reset_n),
      .clock_ratio_straps(clock_ratio_straps), .avm_req(avm_req),
      .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
      .osc_tick(osc_tick), .core_clock_tick(core_clock_tick),
      .periph_clock_tick(periph_clock_tick),
      .sdram_clock_tick(sdram_clock_tick), .core_reset(core_reset));

   rcg_board_model u_rcg_board_model (.clk(clk), .rst_req(rst_req),
      .strap_sel(strap_sel), .reference_clock_in(reference_clock_in),
      .ext_reset_n(ext_reset_n), .clock_ratio_straps(clock_ratio_straps));

   // ==========================================================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one avalon access; holds everything until waitrequest is seen low
   task automatic av(input logic rd, input logic [3:0] a,
                     input logic [31:0] w, output logic [31:0] rv);
      int k;
      k = 0;
      @(posedge clk);
      avm_req <= '{read: rd, write: !rd, address: a, writedata: w};
      do
      begin
         @(posedge clk);
         k++;
      end
      while (avm_waitrequest !== 1'b0 && k < 20);
      rv = avm_readdata;
      avm_req <= '0;
      chk({31'h0, avm_waitrequest}, 32'h0);
   endtask

   task automatic refs(input int k);
      repeat (k) @(posedge reference_clock_in);
   endtask

   task tally_and_finish;
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==========================================================================
   // tick model: events seen between successive reference edges, and between successive pulses of the core, peripheral and sdram ticks
   // the first two intervals are skipped, they straddle a config change
   task automatic step(input int i, input logic ev, input logic inc,
                       input int exp);
      if (ev)
      begin
         if (sn[i] > 1)
            chk(cnt[i], exp);
         cnt[i] = 0;
         sn[i]++;
      end
      if (inc)
         cnt[i]++;
   endtask

   always @(posedge reference_clock_in) ref_cnt++;

   always @(posedge clk)
   begin
      if (!mon_on)
      begin
         sn = '{default: 0};
         cnt = '{default: 0};
      end
      else
      begin
         step(0, reference_clock_in && !ref_q, osc_tick, exp_inc);
         step(1, core_clock_tick, osc_tick, exp_div);
         step(2, periph_clock_tick, core_clock_tick, 2);
         step(3, sdram_clock_tick, core_clock_tick, exp_sd);
      end
      ref_q = reference_clock_in;
   end

   // ==========================================================================
   // watchdog
   initial
   begin
      #(8 * 60000);
      mismatches++;
      tally_and_finish;
   end

   // ==========================================================================
   // main sequence
   initial
   begin
      void'($urandom(19547));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      av(1'b1, 4'h0, '0, d);
      chk(d, {18'h0, 3'h2, 1'b0, 2'h0, 1'b0, SM[0]});
      av(1'b1, 4'h4, '0, d);
      chk(d, 32'h3);
      av(1'b1, 4'h8, '0, d);
      chk(d, 32'h0);
      for (int s = 0; s < 4; s++)
      begin
         strap_sel <= s[1:0];
         refs(3);
         av(1'b1, 4'h0, '0, d);
         chk({25'h0, d[6:0]}, {25'h0, SM[s]});
      end
      av(1'b0, 4'h0, 32'h1309, d);
      av(1'b1, 4'h0, '0, d);
      chk({30'h0, d[9:8]}, 32'h0);
      // release, abort mid-count, then release for good
      rst_req <= 1'b0;
      @(posedge ext_reset_n);
      refs(4);
      chk({31'h0, core_reset}, 32'h1);
      rst_req <= 1'b1;
      refs(2);
      rst_req <= 1'b0;
      @(posedge ext_reset_n);
      n = ref_cnt;
      for (int k = 0; k < 3000 && core_reset !== 1'b0; k++)
         @(posedge clk);
      chk(ref_cnt - n, 8);
      av(1'b1, 4'h4, '0, d);
      chk(d, 32'hc);
      // random ratios; every post-divider code and both halving modes
      for (int i = 0; i < 8; i++)
      begin
         m = $urandom_range(16, 1);
         r = $urandom_range(7, 0);
         wd = {18'h0, r[2:0], i[2], i[1:0], 1'b0, m[6:0]};
         mon_on = 1'b0;
         av(1'b0, 4'h0, wd, d);
         av(1'b1, 4'h0, '0, d);
         chk(d, wd);
         exp_inc = i[2] ? m : 2 * m;
         exp_div = 2 << i[1:0];
         exp_sd = (r == 0) ? 1 : r;
         refs(2);
         mon_on = 1'b1;
         refs(60);
      end
      mon_on = 1'b0;
      rst_req <= 1'b1;
      refs(8);
      av(1'b1, 4'h0, '0, d);
      chk({30'h0, d[9:8]}, 32'h0);
      chk({25'h0, d[6:0]}, {25'h0, SM[3]});
      tally_and_finish;
   end
endmodule
